// [rcls_top.sv]
// Radio control-line sequencer: synthesizer loading and keying lines
// Assumes 200 MHz clock; seven pins are synchronised here, the other inputs (blanker_key_i among them) are not
`timescale 1ns/1ps
module rcls_top
#(
  parameter int unsigned HANG_SHORT = rcls_pkg::HANG_SHORT_CYC,
  parameter int unsigned HANG_LONG  = rcls_pkg::HANG_LONG_CYC,
  parameter int unsigned TONE_HALF  = rcls_pkg::TONE_HALF_CYC
)
(
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          sys_rst_i,
  // Serial load request
  input  wire logic                          load_start_i,
  input  wire logic [1:0]                    load_target_i,
  input  wire logic [rcls_pkg::FRAME_W-1:0]  load_data_i,
  output logic                               load_ready_o,
  // Serial link
  output logic                               sck_o,
  output logic                               mosi_o,
  input  wire logic                          miso_i,
  output logic                               miso_data_o,
  output logic                               first_loop_latch_o,
  output logic                               second_loop_latch_o,
  output logic                               third_loop_latch_o,
  output logic                               serial_busy_out_o,
  // Selective calling audio
  input  wire logic                          sel_rx_gain_i,
  input  wire logic                          sel_rx_on_i,
  input  wire logic                          sel_tx_i,
  input  wire logic                          alert_i,
  input  wire logic [rcls_pkg::PWM_W-1:0]    pwm_duty_i,
  input  wire logic                          alarm_i,
  output logic                               low_gain_audio_sel_n_o,
  output logic                               high_gain_audio_sel_n_o,
  output logic                               external_alarm_out_o,
  // Keying
  input  wire logic                          morse_key_in_n_i,
  input  wire logic                          hang_long_i,
  output logic                               transmit_mode_out_o,
  output logic                               tone_pwm_out_o,
  output logic                               sidetone_alert_out_o,
  output logic                               power_limit_o,
  // Monitor, squelch, blanker
  input  wire logic                          monitor_request_i,
  input  wire logic                          panel_monitor_i,
  input  wire logic                          selcall_mute_i,
  input  wire logic                          squelch_key_i,
  input  wire logic                          blanker_key_i,
  input  wire logic                          blanker_busy_mode_i,
  input  wire logic                          blanker_enable_or_busy_in_i,
  output logic                               blanker_enable_o,
  output logic                               blanker_enable_oe_n_o,
  output logic                               display_hold_o,
  output logic                               monitor_lamp_unmute_o,
  output logic                               squelch_ctrl_out_o,
  output logic                               synthesizer_mute_o,
  // Access and talk sense
  input  wire logic                          program_access_in_n_i,
  input  wire logic                          talk_sense_in_n_i,
  output logic                               program_enable_o,
  output logic                               talk_pressed_o,
  // Async serial option
  input  wire logic                          uart_fitted_i,
  input  wire logic                          uart_tx_data_i,
  input  wire logic                          uart_rx_i,
  output logic                               uart_tx_o,
  output logic                               uart_rx_data_o
);
  import rcls_pkg::*;
  if (HANG_SHORT < 1 || HANG_LONG < HANG_SHORT || TONE_HALF < 1)
  begin
    $error("rcls_top parameters out of range");
  end
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change accepted when stages two and three agree
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] pin_r;
  assign pin_raw = {miso_i, uart_rx_i, blanker_enable_or_busy_in_i,
                    program_access_in_n_i, talk_sense_in_n_i,
                    morse_key_in_n_i, squelch_key_i};
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_r  <= {NPIN{1'b1}};
      s2_r  <= {NPIN{1'b1}};
      s3_r  <= {NPIN{1'b1}};
      pin_r <= {NPIN{1'b1}};
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NPIN; i++)
        if (s2_r[i] == s3_r[i])
          pin_r[i] <= s3_r[i];
    end
  end
  wire logic sq_key   = pin_r[0];
  wire logic key_n    = pin_r[1];
  wire logic talk_n   = pin_r[2];
  wire logic access_n = pin_r[3];
  wire logic busy_pin = pin_r[4];
  ////////////////////////////////////////////////////////////////////////
  // Serial master
  logic [2:0] latch_w;
  rcls_serial
  #(
    .FRAME_W  (FRAME_W),
    .HALF_CYC (SCK_HALF_CYC)
  )
  rcls_serial_inst
  (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (load_start_i),
    .target_i  (load_target_i),
    .data_i    (load_data_i),
    .ready_o   (load_ready_o),
    .sck_o     (sck_o),
    .mosi_o    (mosi_o),
    .latch_o   (latch_w),
    .busy_o    (serial_busy_out_o)
  );
  assign first_loop_latch_o  = latch_w[0];
  assign second_loop_latch_o = latch_w[1];
  assign third_loop_latch_o  = latch_w[2];
  ////////////////////////////////////////////////////////////////////////
  // Keying and hang timer
  logic        key_tx_r;
  logic [31:0] hang_r;
  wire logic   key_down = ~key_n;
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      key_tx_r <= 1'b0;
      hang_r   <= 32'h0;
    end
    else if (key_down)
    begin
      key_tx_r <= 1'b1;
      hang_r   <= 32'h0;
    end
    else if (key_tx_r)
    begin
      if (hang_r >= (hang_long_i ? 32'(HANG_LONG) : 32'(HANG_SHORT)) - 32'h1)
        key_tx_r <= 1'b0;
      else
        hang_r <= hang_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tone generators
  logic [31:0]      sq_cnt_r;
  logic             sq_r;
  logic [PWM_W-1:0] pwm_cnt_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !key_down)
    begin
      sq_cnt_r <= 32'h0;
      sq_r     <= 1'b0;
    end
    else if (sq_cnt_r == 32'(TONE_HALF) - 32'h1)
    begin
      sq_cnt_r <= 32'h0;
      sq_r     <= ~sq_r;
    end
    else
      sq_cnt_r <= sq_cnt_r + 32'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      pwm_cnt_r <= '0;
    else
      pwm_cnt_r <= pwm_cnt_r + PWM_W'(1);
  end

  wire logic sel_tone = sel_tx_i | alert_i;
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      tone_pwm_out_o       <= 1'b0;
      transmit_mode_out_o  <= 1'b0;
      sidetone_alert_out_o <= 1'b0;
      power_limit_o        <= 1'b0;
      external_alarm_out_o <= 1'b0;
    end
    else
    begin
      // 900 Hz square on key down
      tone_pwm_out_o       <= key_down ? sq_r : (sel_tone && (pwm_cnt_r < pwm_duty_i));
      transmit_mode_out_o  <= key_tx_r | key_down | sel_tone;
      sidetone_alert_out_o <= key_tx_r | key_down | alert_i;
      power_limit_o        <= key_tx_r | key_down;
      external_alarm_out_o <= alarm_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Audio path selection
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      low_gain_audio_sel_n_o  <= 1'b1;
      high_gain_audio_sel_n_o <= 1'b1;
    end
    else
    begin
      low_gain_audio_sel_n_o  <= ~(sel_rx_on_i & ~sel_rx_gain_i);
      high_gain_audio_sel_n_o <= ~(sel_rx_on_i & sel_rx_gain_i);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Squelch and blanker toggles
  logic sq_key_d_r;
  logic nb_key_d_r;
  logic squelch_on_r;
  logic blanker_on_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      sq_key_d_r   <= 1'b1;
      nb_key_d_r   <= 1'b0;
      squelch_on_r <= SQUELCH_RST;
      blanker_on_r <= BLANKER_RST;
    end
    else
    begin
      sq_key_d_r <= sq_key;
      nb_key_d_r <= blanker_key_i;
      if (sq_key && !sq_key_d_r)
        squelch_on_r <= ~squelch_on_r;
      if (blanker_key_i && !nb_key_d_r)
        blanker_on_r <= ~blanker_on_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Monitor, mute and blanker line
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      squelch_ctrl_out_o    <= 1'b0;
      synthesizer_mute_o    <= 1'b0;
      monitor_lamp_unmute_o <= 1'b1;
      blanker_enable_o      <= 1'b0;
      blanker_enable_oe_n_o <= 1'b0;
      display_hold_o        <= 1'b0;
    end
    else
    begin
      squelch_ctrl_out_o    <= squelch_on_r & ~monitor_request_i;
      synthesizer_mute_o    <= selcall_mute_i & ~monitor_request_i & ~panel_monitor_i;
      monitor_lamp_unmute_o <= ~selcall_mute_i & ~panel_monitor_i;
      blanker_enable_o      <= blanker_on_r;
      blanker_enable_oe_n_o <= blanker_busy_mode_i;
      display_hold_o        <= blanker_busy_mode_i & busy_pin;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Access, talk sense, async serial
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      program_enable_o <= 1'b0;
      talk_pressed_o   <= 1'b0;
      uart_tx_o        <= 1'b1;
      uart_rx_data_o   <= 1'b1;
      miso_data_o      <= 1'b0;
    end
    else
    begin
      program_enable_o <= ~access_n;
      talk_pressed_o   <= ~talk_n;
      uart_tx_o        <= uart_fitted_i ? uart_tx_data_i : 1'b1;
      uart_rx_data_o   <= uart_fitted_i ? pin_r[5] : 1'b1;
      miso_data_o      <= pin_r[6];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Checks
  key_transmit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(key_down) |-> (transmit_mode_out_o && sidetone_alert_out_o))
    else $error("key down without transmit");
  key_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $fell(key_down) |-> ##1 transmit_mode_out_o[*2])
    else $error("transmit dropped at key up");
  hang_bound_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    hang_r <= 32'(HANG_LONG))
    else $error("hang count overran");
  access_level_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ##1 (program_enable_o == !$past(access_n)))
    else $error("programming enable wrong");
  talk_level_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ##1 (talk_pressed_o == !$past(talk_n)))
    else $error("talk sense wrong");
  gain_excl_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !(~low_gain_audio_sel_n_o && ~high_gain_audio_sel_n_o))
    else $error("both gain channels selected");
  squelch_tog_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (sq_key && !sq_key_d_r) |=> (squelch_on_r != $past(squelch_on_r)))
    else $error("squelch did not toggle");
  mon_open_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    monitor_request_i |=> (!squelch_ctrl_out_o && !synthesizer_mute_o))
    else $error("monitor did not open audio");
endmodule

// [rcls_pkg.sv]
// Package for the radio control-line sequencer
// Assumes a 200 MHz system clock
package rcls_pkg;
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned TONE_HZ          = 900;
  localparam int unsigned TONE_HALF_CYC    = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned HANG_SHORT_MS    = 150;
  localparam int unsigned HANG_LONG_MS     = 500;
  localparam int unsigned HANG_SHORT_CYC   = (CLK_HZ / 1000) * HANG_SHORT_MS;
  localparam int unsigned HANG_LONG_CYC    = (CLK_HZ / 1000) * HANG_LONG_MS;
  localparam int unsigned SCK_HALF_CYC     = 4;
  localparam int unsigned FRAME_W          = 24;
  localparam int unsigned PWM_W            = 8;
  localparam logic [1:0]  TGT_LOOP1        = 2'h0;
  localparam logic [1:0]  TGT_LOOP2        = 2'h1;
  localparam logic [1:0]  TGT_LOOP3        = 2'h2;
  localparam logic [1:0]  TGT_SHREG        = 2'h3;
  localparam logic        SQUELCH_RST      = 1'b0;
  localparam logic        BLANKER_RST      = 1'b0;

  typedef enum logic [1:0]
  {
    RCLS_IDLE  = 2'b00,
    RCLS_SHIFT = 2'b01,
    RCLS_LATCH = 2'b10
  } rcls_state_e;
endpackage

// [rcls_serial.sv]
// Serial master: shifts a frame out MSB first, then pulses one latch (no latch for TGT_SHREG)
// Assumes start only when ready_o is high
`timescale 1ns/1ps
module rcls_serial
#(
  parameter int unsigned FRAME_W  = 24,
  parameter int unsigned HALF_CYC = 4
)
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  // Request
  input  wire logic                 start_i,
  input  wire logic [1:0]           target_i,
  input  wire logic [FRAME_W-1:0]   data_i,
  output logic                      ready_o,
  // Link
  output logic                      sck_o,
  output logic                      mosi_o,
  output logic [2:0]                latch_o,
  output logic                      busy_o
);
  import rcls_pkg::*;

  if (FRAME_W < 1 || FRAME_W > 255 || HALF_CYC < 1 || HALF_CYC > 255)
  begin
    $error("rcls_serial parameters out of range");
  end

  rcls_state_e      state_r;
  logic [FRAME_W-1:0] shift_r;
  logic [7:0]       bits_r;
  logic [7:0]       div_r;
  logic [1:0]       tgt_r;

  assign ready_o = (state_r == RCLS_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Shift and latch sequence
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= RCLS_IDLE;
      shift_r <= '0;
      bits_r  <= 8'h00;
      div_r   <= 8'h00;
      tgt_r   <= 2'h0;
      sck_o   <= 1'b0;
      mosi_o  <= 1'b0;
      latch_o <= 3'h0;
      busy_o  <= 1'b0;
    end
    else
    begin
      latch_o <= 3'h0;
      unique case (state_r)
        RCLS_IDLE:
        begin
          sck_o <= 1'b0;
          if (start_i)
          begin
            state_r <= RCLS_SHIFT;
            shift_r <= data_i << 1;
            mosi_o  <= data_i[FRAME_W-1];
            bits_r  <= 8'(FRAME_W);
            div_r   <= 8'(HALF_CYC - 1);
            tgt_r   <= target_i;
            busy_o  <= 1'b1;
          end
        end
        RCLS_SHIFT:
        begin
          if (div_r != 8'h00)
            div_r <= div_r - 8'h01;
          else
          begin
            div_r <= 8'(HALF_CYC - 1);
            sck_o <= ~sck_o;
            if (sck_o)
            begin
              if (bits_r == 8'h01)
                state_r <= RCLS_LATCH;
              else
              begin
                mosi_o  <= shift_r[FRAME_W-1];
                shift_r <= shift_r << 1;
              end
              bits_r <= bits_r - 8'h01;
            end
          end
        end
        RCLS_LATCH:
        begin
          if (tgt_r != TGT_SHREG)
            latch_o[tgt_r] <= 1'b1;
          busy_o  <= 1'b0;
          state_r <= RCLS_IDLE;
        end
        default:
          state_r <= RCLS_IDLE;
      endcase
    end
  end

  latch_quiet_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (latch_o != 3'h0) |-> ($past(state_r) == RCLS_LATCH && $onehot(latch_o)))
    else $error("latch strobe outside latch step");
  busy_span_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_r == RCLS_SHIFT) |-> busy_o)
    else $error("busy low during shift");
endmodule

// [rcls_partner.sv]
// Model of the synthesizer loops and remote shift registers
// Assumes link lines registered on ref_clk_i
`timescale 1ns/1ps
module rcls_partner
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // Link from master
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  input  wire logic [2:0]  latch_i,
  input  wire logic        busy_i,
  output logic             miso_o,
  // Observation
  output logic [23:0]      word_o,
  output logic [1:0]       tgt_o,
  output logic [5:0]       nbits_o,
  output logic [3:0]       nstb_o,
  output logic             err_o
);
  logic [23:0] sh_r;
  logic [5:0]  cnt_r;
  logic        sck_r;
  logic        busy_r;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i)
  begin
    sck_r  <= sck_i;
    busy_r <= busy_i;
    miso_o <= busy_i ? sh_r[23] : ~sh_r[23];
    if (sys_rst_i)
    begin
      sh_r   <= 24'h0;
      cnt_r  <= 6'h0;
      nstb_o <= 4'h0;
      err_o  <= 1'b0;
    end
    else
    begin
      if (busy_i && !busy_r)
      begin
        cnt_r  <= 6'h0;
        nstb_o <= 4'h0;
      end
      if (busy_i && sck_i && !sck_r)
      begin
        sh_r  <= {sh_r[22:0], mosi_i};
        cnt_r <= cnt_r + 6'h1;
      end
      // shift registers load at frame end
      if (busy_r && !busy_i && latch_i == 3'h0)
      begin
        word_o  <= sh_r;
        tgt_o   <= 2'h3;
        nbits_o <= cnt_r;
      end
      if (latch_i != 3'h0)
      begin
        word_o  <= sh_r;
        tgt_o   <= latch_i[2] ? 2'h2 : (latch_i[1] ? 2'h1 : 2'h0);
        nbits_o <= cnt_r;
        nstb_o  <= nstb_o + 4'h1;
        err_o   <= err_o | busy_i | ($countones(latch_i) != 1);
      end
    end
  end
endmodule

// [rcls_top_bench.sv]
// Self-checking bench for the control-line sequencer
// Assumes short hang and tone counts set below
`timescale 1ns/1ps
module rcls_top_bench;
  import rcls_pkg::*;
  localparam int HS = 50;
  localparam int HL = 100;
  logic        ref_clk_i, sys_rst_i, load_start_i, load_ready_o;
  logic [1:0]  load_target_i, tgt;
  logic [23:0] load_data_i, word;
  logic        sck_o, mosi_o, miso_i, miso_data_o, serial_busy_out_o;
  logic        first_loop_latch_o, second_loop_latch_o, third_loop_latch_o;
  logic        sel_rx_gain_i, sel_rx_on_i, sel_tx_i, alert_i, alarm_i;
  logic [7:0]  pwm_duty_i;
  logic        low_gain_audio_sel_n_o, high_gain_audio_sel_n_o, external_alarm_out_o;
  logic        morse_key_in_n_i, hang_long_i, transmit_mode_out_o, tone_pwm_out_o;
  logic        sidetone_alert_out_o, power_limit_o;
  logic        monitor_request_i, panel_monitor_i, selcall_mute_i, squelch_key_i;
  logic        blanker_key_i, blanker_busy_mode_i, blanker_enable_or_busy_in_i;
  logic        blanker_enable_o, blanker_enable_oe_n_o, display_hold_o, disp_busy;
  logic        monitor_lamp_unmute_o, squelch_ctrl_out_o, synthesizer_mute_o;
  logic        program_access_in_n_i, talk_sense_in_n_i, program_enable_o, talk_pressed_o;
  logic        uart_fitted_i, uart_tx_data_i, uart_rx_i, uart_tx_o, uart_rx_data_o;
  logic [5:0]  nbits;
  logic [3:0]  nstb;
  logic        perr;
  int          n_fail, check_count, cyc, c;
  // Shared pin level from both drivers
  assign blanker_enable_or_busy_in_i = blanker_enable_oe_n_o ? disp_busy : blanker_enable_o;
  rcls_top #(.HANG_SHORT(HS), .HANG_LONG(HL), .TONE_HALF(4)) rcls_top_inst (.*);
  rcls_partner rcls_partner_inst
  (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .sck_i     (sck_o),
    .mosi_i    (mosi_o),
    .latch_i   ({third_loop_latch_o, second_loop_latch_o, first_loop_latch_o}),
    .busy_i    (serial_busy_out_o),
    .miso_o    (miso_i),
    .word_o    (word),
    .tgt_o     (tgt),
    .nbits_o   (nbits),
    .nstb_o    (nstb),
    .err_o     (perr)
  );
  always #2.5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tog(input int n, output int t);
    logic p;
    t = 0;
    repeat (n)
    begin
      p = tone_pwm_out_o;
      step(1);
      if (tone_pwm_out_o !== p)
        t++;
    end
  endtask
  task automatic load(input logic [1:0] t, input logic [23:0] d);
    int w;
    w = 0;
    load_target_i = t;
    load_data_i = d;
    load_start_i = 1'b1;
    step(1);
    load_start_i = 1'b0;
    step(1);
    chk(serial_busy_out_o, 1'b1);
    chk(load_ready_o, 1'b0);
    while (load_ready_o !== 1'b1 && w < 400)
    begin
      step(1);
      w++;
    end
    step(3);
    chk(w >= 190 && w < 400, 1'b1);
    chk(serial_busy_out_o, 1'b0);
    chk(word, d);
    chk(tgt, t);
    chk(nbits, 6'h18);
    chk(nstb, (t == TGT_SHREG) ? 4'h0 : 4'h1);
    chk(perr, 1'b0);
    step(4);
    chk(miso_data_o, !d[23]);
  endtask
  task automatic key_test(input logic lng, input int h);
    hang_long_i = lng;
    morse_key_in_n_i = 1'b0;
    step(8);
    chk(transmit_mode_out_o, 1'b1);
    chk(sidetone_alert_out_o, 1'b1);
    chk(power_limit_o, 1'b1);
    tog(80, c);
    chk(c >= 19 && c <= 21, 1'b1);
    morse_key_in_n_i = 1'b1;
    step(8);
    tog(20, c);
    chk(c, 0);
    step(h - 40);
    chk(transmit_mode_out_o, 1'b1);
    step(30);
    chk(transmit_mode_out_o, 1'b0);
    chk(sidetone_alert_out_o, 1'b0);
    chk(power_limit_o, 1'b0);
  endtask
  task automatic press(input logic sq);
    squelch_key_i = sq;
    blanker_key_i = !sq;
    step(8);
    squelch_key_i = 1'b0;
    blanker_key_i = 1'b0;
    step(8);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    {ref_clk_i, load_start_i, load_target_i, load_data_i, sel_rx_gain_i, sel_rx_on_i} = '0;
    {sel_tx_i, alert_i, pwm_duty_i, alarm_i, hang_long_i, monitor_request_i} = '0;
    {panel_monitor_i, selcall_mute_i, squelch_key_i, blanker_key_i, blanker_busy_mode_i} = '0;
    {disp_busy, uart_fitted_i, uart_tx_data_i, cyc, n_fail, check_count} = '0;
    {morse_key_in_n_i, program_access_in_n_i, talk_sense_in_n_i, uart_rx_i} = 4'hf;
    sys_rst_i = 1'b1;
    step(6);
    sys_rst_i = 1'b0;
    step(6);
    chk({load_ready_o, serial_busy_out_o, sck_o, transmit_mode_out_o}, 4'h8);
    chk({low_gain_audio_sel_n_o, high_gain_audio_sel_n_o, monitor_lamp_unmute_o}, 3'h7);
    $display("test reset done");
    for (int t = 0; t < 4; t++)
      load(t[1:0], 24'h8e1d35 ^ {t[1:0], 22'h2a5a5a});
    $display("test serial done");
    sel_rx_on_i = 1'b1;
    for (int g = 0; g < 2; g++)
    begin
      sel_rx_gain_i = g[0];
      step(8);
      chk({low_gain_audio_sel_n_o, high_gain_audio_sel_n_o}, g[0] ? 2'h2 : 2'h1);
    end
    $display("test gain done");
    key_test(1'b0, HS);
    key_test(1'b1, HL);
    $display("test keying done");
    pwm_duty_i = 8'h80;
    for (int a = 0; a < 2; a++)
    begin
      {alert_i, sel_tx_i} = a[0] ? 2'h2 : 2'h1;
      step(8);
      chk(transmit_mode_out_o, 1'b1);
      chk(sidetone_alert_out_o, a[0]);
      tog(600, c);
      chk(c > 0, 1'b1);
      {alert_i, sel_tx_i} = 2'h0;
      step(8);
    end
    $display("test tone done");
    press(1'b1);
    chk(squelch_ctrl_out_o, 1'b1);
    press(1'b0);
    chk({blanker_enable_o, blanker_enable_oe_n_o}, 2'h2);
    monitor_request_i = 1'b1;
    step(8);
    chk(squelch_ctrl_out_o, 1'b0);
    monitor_request_i = 1'b0;
    selcall_mute_i = 1'b1;
    step(8);
    chk({squelch_ctrl_out_o, synthesizer_mute_o, monitor_lamp_unmute_o}, 3'h6);
    monitor_request_i = 1'b1;
    step(8);
    chk({squelch_ctrl_out_o, synthesizer_mute_o}, 2'h0);
    monitor_request_i = 1'b0;
    panel_monitor_i = 1'b1;
    step(8);
    chk({squelch_ctrl_out_o, synthesizer_mute_o, monitor_lamp_unmute_o}, 3'h4);
    press(1'b1);
    press(1'b0);
    chk({squelch_ctrl_out_o, blanker_enable_o}, 2'h0);
    blanker_busy_mode_i = 1'b1;
    disp_busy = 1'b1;
    step(8);
    chk({blanker_enable_oe_n_o, display_hold_o}, 2'h3);
    disp_busy = 1'b0;
    step(8);
    chk(display_hold_o, 1'b0);
    $display("test monitor done");
    for (int v = 0; v < 2; v++)
    begin
      {alarm_i, uart_fitted_i} = {v[0], 1'b1};
      {program_access_in_n_i, talk_sense_in_n_i, uart_tx_data_i, uart_rx_i} = {4{!v[0]}};
      step(8);
      chk(external_alarm_out_o, v[0]);
      chk({program_enable_o, talk_pressed_o}, {2{v[0]}});
      chk({uart_tx_o, uart_rx_data_o}, {2{!v[0]}});
    end
    $display("test levels done");
    close_out();
  end
endmodule
